// [core/timer_pkg.sv]
// Shared constants for the autoreload wave timer
package timer_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h0d;
    localparam logic [5:0] IDX_CNT_HI = 6'h0e;
    localparam logic [5:0] IDX_CNT_LO = 6'h0f;
    localparam logic [5:0] IDX_RELOAD_HI = 6'h10;
    localparam logic [5:0] IDX_RELOAD_LO = 6'h11;
    localparam logic [5:0] IDX_OUT_CTRL = 6'h12;
    localparam logic [5:0] IDX_WAVE_CS = 6'h13;
    localparam logic [5:0] IDX_DUTY_HI = 6'h17;
    localparam logic [5:0] IDX_DUTY_LO = 6'h18;
    // Control register fields
    localparam int SEL_HI_BIT = 4;
    localparam int SEL_LO_BIT = 3;
    localparam int WRAP_FLAG_BIT = 2;
    localparam int WRAP_IE_BIT = 1;
    localparam int MATCH_IE_BIT = 0;
    // Wave control/status and output control fields
    localparam int POL_BIT = 1;
    localparam int MATCH_FLAG_BIT = 0;
    localparam int OE_BIT = 0;
    // Counter geometry
    localparam int CNT_W = 12;
    localparam logic [11:0] CNT_MAX = 12'hfff;
    localparam logic [11:0] CNT_ZERO = 12'h000;
    localparam int SLOW_DIVIDE = 32;
    // Counter clock selection codes
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_LTIMER = 2'h1;
    localparam logic [1:0] SEL_CPU = 2'h2;
    // Power mode codes on power_mode_i
    localparam logic [2:0] PM_RUN = 3'h0;
    localparam logic [2:0] PM_SLOW = 3'h1;
    localparam logic [2:0] PM_WAIT = 3'h2;
    localparam logic [2:0] PM_ACTIVE_HALT = 3'h3;
    localparam logic [2:0] PM_HALT = 3'h4;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/tick_if.sv]
// Tick carrier between the timer core and its slow-mode divider
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
    logic raw_tick; // Gated tick of the selected counter clock
    logic slow; // Slow mode active
    logic tick; // Tick after division
    modport src (output raw_tick, output slow, input tick);
    modport div (input raw_tick, input slow, output tick);
endinterface // tick_if
`default_nettype wire

// [core/tick_divider.sv]
// Divides the counter tick rate by a fixed ratio in slow mode
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
    parameter int DIV = 32
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    tick_if.div port_io
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_q; // Ticks seen in the current slow period
    logic [CW-1:0] cnt_d;
    logic tick;

    // Pass-through outside slow mode, one out of DIV inside
    always_comb begin
        cnt_d = cnt_q;
        tick = 1'b0;
        if (!port_io.slow) begin
            tick = port_io.raw_tick;
            cnt_d = '0;
        end else if (port_io.raw_tick) begin
            if (cnt_q == CW'(DIV - 1)) begin // [RULE16]
                tick = 1'b1;
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    assign port_io.tick = tick;

    // Division state
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    AST_SLOW_DIVIDE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE16]
        port_io.slow && port_io.tick |-> port_io.raw_tick && cnt_q == CW'(DIV - 1))
        else $error("slow tick not on last divided count");
endmodule // tick_divider
`default_nettype wire

// [core/autoreload_pwm_timer_12bit.sv]
// 12-bit autoreload timer with wave output and compare, AXI4-Lite registers
//
// Overview of operation
// [RULE1] Wave period is 4096 minus reload counts
// [RULE2] Software keeps reload at 4094 or less
// [RULE3] Counter starts from zero after reset
// [RULE4] Software writes duty high byte first
// [RULE5] Wrap reloads counter, loads duty, sets wave
// [RULE6] Counter equal duty clears the wave
// [RULE7] Polarity bit inverts the wave output
// [RULE8] High byte write suspends compare until low
// [RULE9] Software updates duty near wrap safely
// [RULE10] Output enable gates wave onto pin
// [RULE11] Compare mode uses written value immediately
// [RULE12] Compare match sets flag, maybe interrupt
// [RULE13] Zero compare value gives no events
// [RULE14] Every wrap copies duty into shadow
// [RULE15] Compare shadow if enabled, else duty
// [RULE16] Slow mode divides clock by 32
// [RULE17] Halt stops; active-halt stops unless lite wrap
// [RULE18] Separate wrap and match interrupt requests
// [RULE19] Wake rules per power mode
// [RULE20] Software keeps control bits 7:5 cleared
// [RULE21] Clock select: off, lite, cpu, reserved
// [RULE22] Wrap flag set on wrap, read clears
// [RULE23] Match flag set on match, read clears
// [RULE24] Counter advances per tick, holds when off
`timescale 1ns/1ns
`default_nettype none
module autoreload_pwm_timer_12bit
    import timer_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int SLOW_DIV = SLOW_DIVIDE
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // System side
    input wire logic ltimer_tick_i,
    input wire logic [2:0] power_mode_i,
    output logic wave_out_pin_o,
    output logic wave_pin_af_o,
    output logic wrap_irq_o,
    output logic match_irq_o,
    output logic wake_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    // Core state
    logic [11:0] cnt_q, cnt_d; // Up counter
    logic [11:0] reload_q, reload_d; // Reload value
    logic [11:0] duty_q, duty_d; // Duty value as written
    logic [11:0] shadow_q, shadow_d; // Duty copy taken at wrap
    logic lock_q, lock_d; // Compare suspended between byte writes
    logic oe_q, oe_d; // Wave output enable
    logic pol_q, pol_d; // Wave polarity
    logic [1:0] sel_q, sel_d; // Counter clock selection
    logic wrap_ie_q, wrap_ie_d;
    logic match_ie_q, match_ie_d;
    logic wrap_flag_q, wrap_flag_d;
    logic match_flag_q, match_flag_d;
    logic wave_q, wave_d; // Uninverted wave level
    logic pin_q, pin_d; // Registered pin level
    logic wrap_irq_q, wrap_irq_d;
    logic match_irq_q, match_irq_d;
    logic wake_q, wake_d;
    // Core combinational terms
    logic tick; // Counter advances this cycle
    logic sel_tick; // Tick of the selected clock before power gating
    logic run_ok; // Power mode lets the counter run
    logic [11:0] cnt_nxt; // Counter value after this tick
    logic [11:0] cmp_val; // Value compared with the counter
    logic wrap_evt, match_evt;

    // Bus state
    logic aw_held_q, aw_held_d;
    logic [5:0] aw_idx_q, aw_idx_d;
    logic w_held_q, w_held_d;
    logic [7:0] w_byte_q, w_byte_d;
    logic w_lane_q, w_lane_d; // Low byte lane was enabled
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    // Bus to core strobes
    logic wr_en; // Register write commits this cycle
    logic rd_en; // Register read taken this cycle
    logic [5:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit, wr_hit;

    tick_if tick_bus ();

    tick_divider #(
        .DIV(SLOW_DIV)
    ) u_divider (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .port_io(tick_bus.div)
    );

    // Clock selection and power-mode gating ahead of the divider
    always_comb begin
        case (sel_q) // [RULE21]
            SEL_LTIMER: sel_tick = ltimer_tick_i;
            SEL_CPU: sel_tick = 1'b1;
            default: sel_tick = 1'b0; // Off and the reserved code both stop
        endcase
        case (power_mode_i) // [RULE17]
            PM_HALT: run_ok = 1'b0;
            PM_ACTIVE_HALT: run_ok = (sel_q == SEL_LTIMER) && wrap_ie_q;
            default: run_ok = 1'b1; // Wait mode leaves the timer running
        endcase
    end

    assign tick_bus.raw_tick = sel_tick & run_ok;
    assign tick_bus.slow = (power_mode_i == PM_SLOW); // [RULE16]
    assign tick = tick_bus.tick;

    // Byte that a read returns; reserved bits read zero
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx)
            IDX_CTRL: begin
                rd_byte[SEL_HI_BIT:SEL_LO_BIT] = sel_q;
                rd_byte[WRAP_FLAG_BIT] = wrap_flag_q;
                rd_byte[WRAP_IE_BIT] = wrap_ie_q;
                rd_byte[MATCH_IE_BIT] = match_ie_q;
            end
            IDX_CNT_HI: rd_byte[3:0] = cnt_q[11:8];
            IDX_CNT_LO: rd_byte = cnt_q[7:0];
            IDX_RELOAD_HI: rd_byte[3:0] = reload_q[11:8];
            IDX_RELOAD_LO: rd_byte = reload_q[7:0];
            IDX_OUT_CTRL: rd_byte[OE_BIT] = oe_q;
            IDX_WAVE_CS: begin
                rd_byte[POL_BIT] = pol_q;
                rd_byte[MATCH_FLAG_BIT] = match_flag_q;
            end
            IDX_DUTY_HI: rd_byte[3:0] = duty_q[11:8];
            IDX_DUTY_LO: rd_byte = duty_q[7:0];
            default: rd_hit = 1'b0;
        endcase
    end

    // Write decode hit check
    always_comb begin
        case (aw_idx_q)
            IDX_CTRL, IDX_CNT_HI, IDX_CNT_LO, IDX_RELOAD_HI, IDX_RELOAD_LO,
            IDX_OUT_CTRL, IDX_WAVE_CS, IDX_DUTY_HI, IDX_DUTY_LO: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Next state of the timer core
    always_comb begin
        cnt_d = cnt_q;
        reload_d = reload_q;
        duty_d = duty_q;
        shadow_d = shadow_q;
        lock_d = lock_q;
        oe_d = oe_q;
        pol_d = pol_q;
        sel_d = sel_q;
        wrap_ie_d = wrap_ie_q;
        match_ie_d = match_ie_q;
        wave_d = wave_q;
        // Compare source follows the output mode
        cmp_val = oe_q ? shadow_q : duty_q; // [RULE15] [RULE11]
        // Wrap from the maximum back to reload sets the period
        cnt_nxt = (cnt_q == CNT_MAX) ? reload_q : cnt_q + 1'b1; // [RULE1]
        wrap_evt = tick && (cnt_q == CNT_MAX); // [RULE22]
        // Zero value and a half-written value never match
        match_evt = tick && !lock_q && (cmp_val != CNT_ZERO) // [RULE8] [RULE13]
            && (cnt_nxt == cmp_val); // [RULE12]
        if (tick) begin
            cnt_d = cnt_nxt; // [RULE24]
        end
        if (wrap_evt) begin
            shadow_d = duty_q; // [RULE5] [RULE14]
            wave_d = 1'b1; // [RULE5]
        end
        // Match after the wrap edge wins, so duty equal reload gives a flat line
        if (match_evt && oe_q) begin
            wave_d = 1'b0; // [RULE6]
        end
        // Hardware set beats a read clear in the same cycle
        wrap_flag_d = wrap_evt
            | (wrap_flag_q & ~(rd_en && rd_idx == IDX_CTRL)); // [RULE22]
        match_flag_d = match_evt
            | (match_flag_q & ~(rd_en && rd_idx == IDX_WAVE_CS)); // [RULE23]
        // Software register writes; counter is read-only
        if (wr_en && w_lane_q) begin
            case (aw_idx_q)
                IDX_CTRL: begin
                    sel_d = w_byte_q[SEL_HI_BIT:SEL_LO_BIT]; // [RULE21]
                    wrap_ie_d = w_byte_q[WRAP_IE_BIT];
                    match_ie_d = w_byte_q[MATCH_IE_BIT];
                end
                IDX_RELOAD_HI: reload_d[11:8] = w_byte_q[3:0];
                IDX_RELOAD_LO: reload_d[7:0] = w_byte_q;
                IDX_OUT_CTRL: oe_d = w_byte_q[OE_BIT];
                IDX_WAVE_CS: pol_d = w_byte_q[POL_BIT];
                IDX_DUTY_HI: begin
                    duty_d[11:8] = w_byte_q[3:0];
                    lock_d = 1'b1; // [RULE8]
                end
                IDX_DUTY_LO: begin
                    duty_d[7:0] = w_byte_q;
                    lock_d = 1'b0; // [RULE8] [RULE11]
                end
                default: ;
            endcase
        end
        pin_d = oe_q & (wave_q ^ pol_q); // [RULE7] [RULE10]
        // Each event has its own request line
        wrap_irq_d = wrap_flag_q & wrap_ie_q; // [RULE18]
        match_irq_d = match_flag_q & match_ie_q; // [RULE18]
        // Wake: wait by either, active-halt by lite-clocked wrap only
        wake_d = ((power_mode_i == PM_WAIT) && (wrap_irq_q || match_irq_q))
            || ((power_mode_i == PM_ACTIVE_HALT) && wrap_irq_q
            && (sel_q == SEL_LTIMER)); // [RULE19]
    end

    // Core registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cnt_q <= CNT_ZERO; // [RULE3]
            reload_q <= CNT_ZERO;
            duty_q <= CNT_ZERO;
            shadow_q <= CNT_ZERO;
            lock_q <= 1'b0;
            oe_q <= 1'b0;
            pol_q <= 1'b0;
            sel_q <= SEL_OFF; // [RULE21]
            wrap_ie_q <= 1'b0;
            match_ie_q <= 1'b0;
            wrap_flag_q <= 1'b0;
            match_flag_q <= 1'b0;
            wave_q <= 1'b0;
            pin_q <= 1'b0;
            wrap_irq_q <= 1'b0;
            match_irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            reload_q <= reload_d;
            duty_q <= duty_d;
            shadow_q <= shadow_d;
            lock_q <= lock_d;
            oe_q <= oe_d;
            pol_q <= pol_d;
            sel_q <= sel_d;
            wrap_ie_q <= wrap_ie_d;
            match_ie_q <= match_ie_d;
            wrap_flag_q <= wrap_flag_d;
            match_flag_q <= match_flag_d;
            wave_q <= wave_d;
            pin_q <= pin_d;
            wrap_irq_q <= wrap_irq_d;
            match_irq_q <= match_irq_d;
            wake_q <= wake_d;
        end
    end

    // Bus handshakes
    assign s_axi_awready_o = !aw_held_q;
    assign s_axi_wready_o = !w_held_q;
    assign s_axi_arready_o = !rvalid_q;
    assign wr_en = aw_held_q && w_held_q && !bvalid_q;
    assign rd_en = s_axi_arvalid_i && !rvalid_q;
    assign rd_idx = s_axi_araddr_i[7:2];

    // Next state of the AXI4-Lite slave
    always_comb begin
        aw_held_d = aw_held_q;
        aw_idx_d = aw_idx_q;
        w_held_d = w_held_q;
        w_byte_d = w_byte_q;
        w_lane_d = w_lane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        // Address and data are caught in either order
        if (s_axi_awvalid_i && !aw_held_q) begin
            aw_held_d = 1'b1;
            aw_idx_d = s_axi_awaddr_i[7:2];
        end
        if (s_axi_wvalid_i && !w_held_q) begin
            w_held_d = 1'b1;
            w_byte_d = s_axi_wdata_i[7:0];
            w_lane_d = s_axi_wstrb_i[0];
        end
        // Commit once both are held; unmapped gets an error response
        if (wr_en) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        // Read data captured at the address handshake
        if (rd_en) begin
            rvalid_d = 1'b1;
            rdata_d = {24'h000000, rd_byte};
            rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
    end

    // Bus registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            aw_held_q <= 1'b0;
            aw_idx_q <= 6'h00;
            w_held_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            aw_idx_q <= aw_idx_d;
            w_held_q <= w_held_d;
            w_byte_q <= w_byte_d;
            w_lane_q <= w_lane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign wave_out_pin_o = pin_q;
    assign wave_pin_af_o = oe_q; // [RULE10]
    assign wrap_irq_o = wrap_irq_q;
    assign match_irq_o = match_irq_q;
    assign wake_o = wake_q;

    AST_RESET_ZERO: assert property (@(posedge clock_i) disable iff (1'b0) // [RULE3]
        sys_rst_i |=> cnt_q == CNT_ZERO && sel_q == SEL_OFF)
        else $error("counter or clock select not cleared by reset");
    AST_WRAP_RELOAD: assert property (tick && cnt_q == CNT_MAX // [RULE5]
        |=> cnt_q == $past(reload_q) && shadow_q == $past(duty_q))
        else $error("wrap did not reload counter and shadow");
    AST_WRAP_HIGH: assert property (wrap_evt && !match_evt |=> wave_q) // [RULE5]
        else $error("wave not high after wrap");
    AST_MATCH_LOW: assert property (match_evt && oe_q |=> !wave_q ##1 // [RULE6]
        (pin_q == ($past(oe_q) & $past(pol_q))))
        else $error("wave not low after match");
    AST_PIN_POL: assert property ($past(oe_q) && $past(pol_q) // [RULE7]
        |-> pin_q == !$past(wave_q))
        else $error("polarity not applied to pin");
    AST_PIN_GATE: assert property (!oe_q |=> !pin_q) // [RULE10]
        else $error("pin driven while output disabled");
    AST_LOCK: assert property (wr_en && w_lane_q && aw_idx_q == IDX_DUTY_HI // [RULE8]
        |=> !match_evt throughout (lock_q [*2]))
        else $error("compare ran while high byte pending");
    AST_ZERO_CMP: assert property ((oe_q ? shadow_q : duty_q) == CNT_ZERO // [RULE13]
        |-> !match_evt)
        else $error("match on zero compare value");
    AST_MATCH_FLAG: assert property (match_evt |=> match_flag_q ##1 // [RULE12]
        (match_irq_q == $past(match_ie_q)))
        else $error("match flag or request missing");
    AST_WRAP_FLAG: assert property (wrap_evt |=> wrap_flag_q) // [RULE22]
        else $error("wrap flag not set");
    AST_CTRL_CLEAR: assert property (rd_en && rd_idx == IDX_CTRL && !wrap_evt // [RULE22]
        |=> !wrap_flag_q)
        else $error("wrap flag not cleared by read");
    AST_HOLD_OFF: assert property (sel_q == SEL_OFF |=> cnt_q == $past(cnt_q)) // [RULE24]
        else $error("counter moved while clock off");
    AST_HALT: assert property (power_mode_i == PM_HALT |-> !tick) // [RULE17]
        else $error("counter ticked in halt");
endmodule // autoreload_pwm_timer_12bit
`default_nettype wire

// [test/autoreload_pwm_timer_12bit_test.sv]
// Self-checking bench for the autoreload wave timer over AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
module autoreload_pwm_timer_12bit_test;
import timer_pkg::*;
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
logic clk = 1'b0; // Bench clock, 8 ns period
logic rst = 1'b1; // Synchronous reset, high
logic [7:0] aw_addr = 8'h00;
logic aw_valid = 1'b0;
logic aw_ready;
logic [31:0] w_data = 32'h0;
logic w_valid = 1'b0;
logic w_ready;
logic [1:0] b_resp;
logic b_valid;
logic b_ready = 1'b0;
logic [7:0] ar_addr = 8'h00;
logic ar_valid = 1'b0;
logic ar_ready;
logic [31:0] r_data;
logic [1:0] r_resp;
logic r_valid;
logic r_ready = 1'b0;
logic lt_tick = 1'b0; // Lite-timer tick pulse
logic [1:0] tick_cnt = 2'h0;
logic [2:0] pm = PM_RUN; // Power mode
logic pin, af, wrap_irq, match_irq, wake;
int n_fail = 0;
int checked = 0;
logic [31:0] d, d2;
logic [1:0] rsp;
logic seen;
int hi, ri;
autoreload_pwm_timer_12bit dut (.clock_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
    .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
    .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready), .ltimer_tick_i(lt_tick),
    .power_mode_i(pm), .wave_out_pin_o(pin), .wave_pin_af_o(af), .wrap_irq_o(wrap_irq),
    .match_irq_o(match_irq), .wake_o(wake));
// Free-running clock
always #4 clk = ~clk;
// Lite tick every fourth cycle, so lite-clocked counting is visibly slower
always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    lt_tick <= (tick_cnt == 2'h3);
end
// Closing report, the only place the run ends
task automatic results();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
// AXI write of one byte; ready is sampled 1 ns after each edge
task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    int n;
    logic a, w, b;
    @(posedge clk);
    aw_addr <= {idx, 2'b00};
    aw_valid <= 1'b1;
    w_data <= {24'h0, val};
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    n = 0;
    b = 1'b0;
    while (!b && n < 100) begin
        #1;
        a = aw_valid & (aw_ready === 1'b1);
        w = w_valid & (w_ready === 1'b1);
        b = (b_valid === 1'b1);
        rsp = b_resp;
        @(posedge clk);
        if (a) aw_valid <= 1'b0;
        if (w) w_valid <= 1'b0;
        n++;
    end
    b_ready <= 1'b0;
    // Hung slave counts as a failure
    if (!b) begin n_fail++; results(); end
endtask
// AXI read; data and response taken 1 ns after the edge on which valid is first seen
task automatic rd(input logic [5:0] idx, output logic [31:0] dat);
    int n;
    logic a, r;
    @(posedge clk);
    ar_addr <= {idx, 2'b00};
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    n = 0;
    r = 1'b0;
    while (!r && n < 100) begin
        #1;
        a = ar_valid & (ar_ready === 1'b1);
        r = (r_valid === 1'b1);
        dat = r_data;
        rsp = r_resp;
        @(posedge clk);
        if (a) ar_valid <= 1'b0;
        n++;
    end
    r_ready <= 1'b0;
    if (!r) begin n_fail++; results(); end
endtask
// Counts high samples and rising edges of the pin over len cycles
task automatic meas(input int len, output int h, output int rs);
    logic prev;
    h = 0;
    rs = 0;
    @(posedge clk);
    #1 prev = pin;
    repeat (len) begin
        @(posedge clk);
        #1;
        if (pin === 1'b1) h++;
        if (pin === 1'b1 && prev === 1'b0) rs++;
        prev = pin;
    end
endtask
// Bounded wait for wrap irq (0), match irq (1) or wake (2)
task automatic wait_sig(input int which, input int lim, output logic s);
    s = 1'b0;
    for (int n = 0; n < lim && !s; n++) begin
        @(posedge clk);
        #1;
        s = (which == 0) ? (wrap_irq === 1'b1) : (which == 1) ? (match_irq === 1'b1)
            : (wake === 1'b1);
    end
endtask
// Table of every mapped register for the reset sweep
logic [5:0] ridx [9] = '{IDX_CTRL, IDX_CNT_HI, IDX_CNT_LO, IDX_RELOAD_HI, IDX_RELOAD_LO,
    IDX_OUT_CTRL, IDX_WAVE_CS, IDX_DUTY_HI, IDX_DUTY_LO};
// Main sequence
initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ridx[i]) begin
        rd(ridx[i], d);
        `CHK("reset value", 32'h0, d)
    end
    rd(6'h14, d);
    `CHK("unmapped read", RESP_SLVERR, rsp)
    wr(6'h14, 8'h55);
    `CHK("unmapped write", RESP_SLVERR, rsp)
    $display("test reset done");
    // Period 6 counts, high from 0xffa to 0xffc; duty set while the counter is stopped
    wr(IDX_RELOAD_HI, 8'h0f);
    wr(IDX_RELOAD_LO, 8'hfa);
    wr(IDX_DUTY_HI, 8'h0f);
    wr(IDX_DUTY_LO, 8'hfc);
    wr(IDX_OUT_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h12);
    `CHK("write resp", RESP_OKAY, rsp)
    // First pass climbs from zero, so the wave only starts after a full 4096 counts
    repeat (4120) @(posedge clk);
    `CHK("pin af", 1'b1, af)
    meas(60, hi, ri);
    `CHK("wave rises", 10, ri)
    `CHK("wave high", 20, hi)
    wr(IDX_WAVE_CS, 8'h02);
    repeat (12) @(posedge clk);
    meas(60, hi, ri);
    `CHK("inverted high", 40, hi)
    wait_sig(0, 20, seen);
    `CHK("wrap irq", 1'b1, seen)
    rd(IDX_CTRL, d);
    `CHK("ctrl read", 32'h16, d)
    `CHK("read resp", RESP_OKAY, rsp)
    $display("test wave done");
    // Slow mode stretches the period by the divider
    @(posedge clk);
    pm <= PM_SLOW;
    repeat (200) @(posedge clk);
    meas(384, hi, ri);
    `CHK("slow rises", 2, ri)
    @(posedge clk);
    pm <= PM_WAIT;
    wait_sig(2, 20, seen);
    `CHK("wait wake", 1'b1, seen)
    meas(60, hi, ri);
    `CHK("wait rises", 10, ri)
    @(posedge clk);
    pm <= PM_HALT;
    repeat (4) @(posedge clk);
    rd(IDX_CNT_LO, d);
    rd(IDX_CNT_LO, d2);
    `CHK("halt count", d, d2)
    #1;
    `CHK("halt wake", 1'b0, wake)
    // Active-halt keeps running on the lite tick with wrap irq on
    wr(IDX_CTRL, 8'h0a);
    rd(IDX_CTRL, d);
    @(posedge clk);
    pm <= PM_ACTIVE_HALT;
    wait_sig(2, 200, seen);
    `CHK("active halt wake", 1'b1, seen)
    @(posedge clk);
    pm <= PM_RUN;
    wr(IDX_CTRL, 8'h00);
    rd(IDX_CNT_LO, d);
    repeat (5) @(posedge clk);
    rd(IDX_CNT_LO, d2);
    `CHK("off holds", d, d2)
    // Reserved select code must stop the counter like off
    wr(IDX_CTRL, 8'h18);
    rd(IDX_CNT_LO, d);
    repeat (5) @(posedge clk);
    rd(IDX_CNT_LO, d2);
    `CHK("reserved holds", d, d2)
    $display("test power done");
    // Compare mode, full 4096-count period
    wr(IDX_OUT_CTRL, 8'h00);
    wr(IDX_RELOAD_HI, 8'h00);
    wr(IDX_RELOAD_LO, 8'h00);
    wr(IDX_DUTY_HI, 8'h00);
    wr(IDX_DUTY_LO, 8'h00);
    wr(IDX_CTRL, 8'h11);
    rd(IDX_WAVE_CS, d);
    wait_sig(1, 4300, seen);
    `CHK("zero no match", 1'b0, seen)
    wr(IDX_DUTY_HI, 8'h01);
    wait_sig(1, 4300, seen);
    `CHK("locked no match", 1'b0, seen)
    wr(IDX_DUTY_LO, 8'h10);
    wait_sig(1, 4300, seen);
    `CHK("match irq", 1'b1, seen)
    `CHK("pin idle", 1'b0, pin)
    rd(IDX_WAVE_CS, d);
    `CHK("match flag", 1'b1, d[0])
    wr(IDX_CTRL, 8'h10);
    repeat (3) @(posedge clk);
    `CHK("match masked", 1'b0, match_irq)
    $display("test compare done");
    results();
end
endmodule // autoreload_pwm_timer_12bit_test
`default_nettype wire
